/* sccp_device.sv */
// Contract
// - Bus idle only when both lines high
// - Data falls while clock high: START
// - Data rises while clock high: STOP
// - Data changes only while clock low
// - Any byte count between START and STOP
// - Eight bits then ninth acknowledge bit
// - Addressed receiving device acknowledges every byte
// - Master acknowledges all but last read
// - Acknowledger holds data low through high
// - No acknowledge: device releases data line
// - Write: direction 0, then word address
// - Write data stored, pointer advances on ack
// - Device acknowledges address, word, data bytes
// - Repeated START, direction 1 reads addressed byte
// - Read pointer advances only on master ack
// - Reading continues until master STOP
// - Read without pointer write uses old pointer
// - Correction acts at divide-by-128 stage; the code corrects at the divide-by-256 stage
// - Calibration magnitude is low five bits
// - Bit five: one adds, zero blanks
// - 64-minute cycle, last two untouched
// - First 2N minutes get one correction
// - Power fail aborts, resets pointer, ignores bus
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`default_nettype none
module sccp_device
    import sccp_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h68,
    parameter int PTR_W = 6
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    sccp_link_if.device link,
    input wire logic osc_in,
    input wire logic power_fail_in,
    output logic second_tick_out,
    output logic [7:0] clock_control_out
);

    // ********************************
    // Input synchronisers
    // ********************************
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] osc_sync_reg;
    logic [1:0] pf_sync_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    logic osc_d_reg;

    // Every pin passes two flops; edges are taken from the second stage only
    always_ff @(posedge clk_in)
    begin
        scl_sync_reg <= {scl_sync_reg[0], link.scl};
        sda_sync_reg <= {sda_sync_reg[0], link.sda};
        osc_sync_reg <= {osc_sync_reg[0], osc_in};
        pf_sync_reg <= {pf_sync_reg[0], power_fail_in};
        scl_d_reg <= scl_sync_reg[1];
        sda_d_reg <= sda_sync_reg[1];
        osc_d_reg <= osc_sync_reg[1];
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic power_fail;

    // Both lines pass the same flops, so their relative order is kept
    assign scl_rise = scl_sync_reg[1] & ~scl_d_reg;
    assign scl_fall = ~scl_sync_reg[1] & scl_d_reg;
    assign start_det = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
    assign stop_det = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];
    assign power_fail = pf_sync_reg[1];

    // ********************************
    // Storage
    // ********************************
    logic [7:0] mem [2**PTR_W];
    logic [7:0] ctrl_reg;
    logic [PTR_W-1:0] ptr_reg;

    // The control location sits on top of the array so it can have a reset value
    function automatic logic [7:0] read_loc(input logic [PTR_W-1:0] loc, input logic [7:0] ctrl);
        read_loc = (loc == PTR_W'(CTRL_LOC)) ? ctrl : mem[loc];
    endfunction

    // ********************************
    // Serial slave
    // ********************************
    sccp_dev_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [1:0] byte_idx_reg;
    logic rw_reg;
    logic mack_reg;
    logic sda_oe_n_reg;
    logic sda_o_reg;
    logic [7:0] tx_byte;
    logic wr_en;

    assign tx_byte = read_loc(ptr_reg, ctrl_reg);
    // Data byte complete on the falling edge after its eighth bit
    assign wr_en = (state_reg == DS_RX) && scl_fall && (bit_cnt_reg == 4'h8) && (byte_idx_reg == 2'h2)
        && !power_fail && !start_det && !stop_det;

    // Open drain: the driven value is always low, only the enable moves
    always_ff @(posedge clk_in)
    begin
        sda_o_reg <= 1'b0;
    end

    // Protocol engine; power fail dominates everything but reset
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || power_fail)
        begin
            state_reg <= DS_IDLE;
            sda_oe_n_reg <= 1'b1;
            ptr_reg <= '0;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            byte_idx_reg <= 2'h0;
            rw_reg <= 1'b0;
            mack_reg <= 1'b0;
        end
        else if (start_det)
        begin
            // A repeated START restarts from the address byte; pointer kept
            state_reg <= DS_RX;
            sda_oe_n_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
        end
        else if (stop_det)
        begin
            state_reg <= DS_IDLE;
            sda_oe_n_reg <= 1'b1;
        end
        else
        begin
            unique case (state_reg)
                DS_IDLE:
                begin
                end
                DS_RX:
                begin
                    if (scl_rise && bit_cnt_reg < 4'h8)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_reg == 4'h8)
                    begin
                        if (byte_idx_reg == 2'h0 && shift_reg[7:1] != SLAVE_ADDR)
                        begin
                            state_reg <= DS_IDLE;
                        end
                        else
                        begin
                            if (byte_idx_reg == 2'h0)
                            begin
                                rw_reg <= shift_reg[0];
                            end
                            if (byte_idx_reg == 2'h1)
                            begin
                                ptr_reg <= shift_reg[PTR_W-1:0];
                            end
                            sda_oe_n_reg <= 1'b0;
                            state_reg <= DS_ACK;
                        end
                    end
                end
                DS_ACK:
                begin
                    // Release only after the acknowledge clock has fallen
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (byte_idx_reg == 2'h0 && rw_reg)
                        begin
                            shift_reg <= tx_byte;
                            sda_oe_n_reg <= tx_byte[7];
                            state_reg <= DS_TX;
                        end
                        else
                        begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= DS_RX;
                            if (byte_idx_reg == 2'h2)
                            begin
                                ptr_reg <= ptr_reg + PTR_W'(1);
                            end
                            else
                            begin
                                byte_idx_reg <= byte_idx_reg + 2'h1;
                            end
                        end
                    end
                end
                DS_TX:
                begin
                    // New bit only after the clock is seen low
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == 4'h7)
                        begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= DS_MACK;
                        end
                        else
                        begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sda_oe_n_reg <= shift_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                DS_MACK:
                begin
                    if (scl_rise)
                    begin
                        mack_reg <= ~sda_sync_reg[1];
                        if (!sda_sync_reg[1])
                        begin
                            ptr_reg <= ptr_reg + PTR_W'(1);
                        end
                    end
                    else if (scl_fall)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (mack_reg)
                        begin
                            shift_reg <= tx_byte;
                            sda_oe_n_reg <= tx_byte[7];
                            state_reg <= DS_TX;
                        end
                        else
                        begin
                            // Line stays released so the master can issue STOP
                            state_reg <= DS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Byte write into the array; the control byte has its own reset flop
    always_ff @(posedge clk_in)
    begin
        if (wr_en)
        begin
            mem[ptr_reg] <= shift_reg;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_reg <= CTRL_RESET;
        end
        else if (wr_en && ptr_reg == PTR_W'(CTRL_LOC))
        begin
            ctrl_reg <= shift_reg;
        end
    end

    // ********************************
    // Divider chain and calibration
    // ********************************
    logic [6:0] pre_reg;
    logic [8:0] stage_reg;
    logic [5:0] sec_reg;
    logic [5:0] min_reg;
    logic tick_reg;
    logic osc_rise;
    logic [4:0] cal_mag;
    logic corr_sec;
    logic [8:0] stage_term;

    assign osc_rise = osc_sync_reg[1] & ~osc_d_reg;
    assign cal_mag = ctrl_reg[CAL_MAG_LSB +: CAL_MAG_W];
    // Second zero of each of the first 2N minutes, never the last two
    assign corr_sec = (sec_reg == 6'h00) && (min_reg < {cal_mag, 1'b0})
        && (min_reg < 6'(CAL_LAST_MIN));
    // Count is moved at the divide-by-256 stage, never inside the divide-by-128 prescaler
    assign stage_term = !corr_sec ? STAGE_TERM_NORM
        : (ctrl_reg[CAL_SIGN_BIT] ? STAGE_TERM_FAST : STAGE_TERM_SLOW);

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            pre_reg <= 7'h00;
            stage_reg <= 9'h000;
            sec_reg <= 6'h00;
            min_reg <= 6'h00;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= 1'b0;
            if (osc_rise)
            begin
                pre_reg <= pre_reg + 7'h01;
                if (pre_reg == 7'(PRE_DIV - 1))
                begin
                    stage_reg <= stage_reg + 9'h001;
                    if (stage_reg >= stage_term)
                    begin
                        stage_reg <= 9'h000;
                        tick_reg <= 1'b1;
                        sec_reg <= (sec_reg == 6'(SEC_PER_MIN - 1)) ? 6'h00 : sec_reg + 6'h01;
                        if (sec_reg == 6'(SEC_PER_MIN - 1))
                        begin
                            min_reg <= (min_reg == 6'(CAL_CYCLE_MIN - 1)) ? 6'h00 : min_reg + 6'h01;
                        end
                    end
                end
            end
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign second_tick_out = tick_reg;
    assign clock_control_out = ctrl_reg;
    assign link.sda_d_oe_n = sda_oe_n_reg;
    assign link.sda_d_o = sda_o_reg;

endmodule
`default_nettype wire

/* sccp_host.sv */
`default_nettype none
module sccp_host
    import sccp_pkg::*;
#(
    parameter int HALF_CYCLES = SCL_HALF_CYCLES
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    sccp_link_if.host link,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);

    // ********************************
    // Data line synchroniser
    // ********************************
    logic [1:0] sda_sync_reg;

    always_ff @(posedge clk_in)
    begin
        sda_sync_reg <= {sda_sync_reg[0], link.sda};
    end

    // ********************************
    // Avalon-MM slave
    // ********************************
    sccp_host_state_e state_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [8:0] rx_reg;
    logic busy;
    logic accept;
    logic cmd_go;

    assign busy = (state_reg != HS_IDLE);
    // A command while the engine runs is held off by waitrequest, not dropped
    assign accept = (avs_read_in || avs_write_in) && wait_reg
        && !(avs_write_in && avs_address_in == CMD_OFF && busy);
    assign cmd_go = !wait_reg && avs_write_in && avs_address_in == CMD_OFF;

    // Answer one cycle after the request is seen; unmapped reads return zero
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            wait_reg <= !accept;
            if (accept)
            begin
                rdata_reg <= 32'h0000_0000;
                if (avs_address_in == STAT_OFF)
                begin
                    rdata_reg[STAT_BUSY_BIT] <= busy;
                    rdata_reg[STAT_NACK_BIT] <= rx_reg[0];
                    rdata_reg[STAT_RX_LSB +: 8] <= rx_reg[8:1];
                end
            end
        end
    end

    // ********************************
    // Bit engine
    // ********************************
    logic [15:0] tmr_reg;
    logic [3:0] bit_reg;
    logic [8:0] tx_reg;
    logic stop_reg;
    logic scl_oe_n_reg;
    logic sda_oe_n_reg;
    logic zero_reg;
    logic tdone;

    assign tdone = (tmr_reg == 16'(HALF_CYCLES - 1));

    always_ff @(posedge clk_in)
    begin
        zero_reg <= 1'b0;
    end

    // Each phase lasts one half period of the link clock
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_reg <= HS_IDLE;
            tmr_reg <= 16'h0000;
            bit_reg <= 4'h0;
            tx_reg <= 9'h1FF;
            rx_reg <= 9'h000;
            stop_reg <= 1'b0;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
        end
        else
        begin
            tmr_reg <= (state_reg == HS_IDLE || tdone) ? 16'h0000 : tmr_reg + 16'h0001;
            unique case (state_reg)
                HS_IDLE:
                begin
                    if (cmd_go)
                    begin
                        // A read frame releases data and drives only the ack slot
                        tx_reg <= avs_writedata_in[CMD_READ_BIT] ? {8'hFF, avs_writedata_in[CMD_NACK_BIT]}
                            : {avs_writedata_in[7:0], 1'b1};
                        stop_reg <= avs_writedata_in[CMD_STOP_BIT];
                        bit_reg <= 4'h0;
                        if (avs_writedata_in[CMD_START_BIT])
                        begin
                            state_reg <= HS_START_A;
                        end
                        else if (avs_writedata_in[CMD_NOBYTE_BIT])
                        begin
                            state_reg <= avs_writedata_in[CMD_STOP_BIT] ? HS_STOP_A : HS_IDLE;
                        end
                        else
                        begin
                            state_reg <= HS_BIT_LOW;
                        end
                    end
                end
                HS_START_A:
                begin
                    sda_oe_n_reg <= 1'b1;
                    state_reg <= tdone ? HS_START_B : HS_START_A;
                end
                HS_START_B:
                begin
                    scl_oe_n_reg <= 1'b1;
                    state_reg <= tdone ? HS_START_C : HS_START_B;
                end
                HS_START_C:
                begin
                    sda_oe_n_reg <= 1'b0;
                    if (tdone)
                    begin
                        scl_oe_n_reg <= 1'b0;
                        state_reg <= HS_BIT_LOW;
                    end
                end
                HS_BIT_LOW:
                begin
                    sda_oe_n_reg <= tx_reg[8];
                    if (tdone)
                    begin
                        scl_oe_n_reg <= 1'b1;
                        state_reg <= HS_BIT_HIGH;
                    end
                end
                HS_BIT_HIGH:
                begin
                    if (tdone)
                    begin
                        rx_reg <= {rx_reg[7:0], sda_sync_reg[1]};
                        tx_reg <= {tx_reg[7:0], 1'b1};
                        scl_oe_n_reg <= 1'b0;
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == 4'h8)
                        begin
                            state_reg <= stop_reg ? HS_STOP_A : HS_IDLE;
                        end
                        else
                        begin
                            state_reg <= HS_BIT_LOW;
                        end
                    end
                end
                HS_STOP_A:
                begin
                    scl_oe_n_reg <= 1'b0;
                    sda_oe_n_reg <= 1'b0;
                    state_reg <= tdone ? HS_STOP_B : HS_STOP_A;
                end
                HS_STOP_B:
                begin
                    scl_oe_n_reg <= 1'b1;
                    state_reg <= tdone ? HS_STOP_C : HS_STOP_B;
                end
                HS_STOP_C:
                begin
                    sda_oe_n_reg <= 1'b1;
                    state_reg <= tdone ? HS_IDLE : HS_STOP_C;
                end
            endcase
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign link.scl_oe_n = scl_oe_n_reg;
    assign link.scl_o = zero_reg;
    assign link.sda_h_oe_n = sda_oe_n_reg;
    assign link.sda_h_o = zero_reg;

endmodule
`default_nettype wire

/* sccp_link_if.sv */
`default_nettype none
interface sccp_link_if;
    logic scl_o;
    logic scl_oe_n;
    logic sda_h_o;
    logic sda_h_oe_n;
    logic sda_d_o;
    logic sda_d_oe_n;
    logic scl;
    logic sda;

    // Open-drain wires with pull-up: low only where an enabled driver pulls low
    assign scl = scl_oe_n | scl_o;
    assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);

    modport host (output scl_o, output scl_oe_n, output sda_h_o, output sda_h_oe_n, input scl, input sda);
    modport device (output sda_d_o, output sda_d_oe_n, input scl, input sda);
endinterface
`default_nettype wire

/* sccp_link_monitor.sv */
`default_nettype none
module sccp_link_monitor (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_h_o,
    input wire logic sda_h_oe_n,
    input wire logic sda_d_o,
    input wire logic sda_d_oe_n,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // Wire checks
    // ****************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // Open drain only: a driven high would fight the pull-up
    a_drive_low_only: assert property (!scl_o && !sda_h_o && !sda_d_o) else $error("line driven high");
    a_dev_chg_low: assert property ($changed(sda_d_oe_n) |-> !scl && !$past(scl)) else $error("sda moved");
    a_dev_resp_time: assert property ($changed(sda_d_oe_n) |-> $past(scl, 4) || $past(scl, 5) || $past(scl, 6))
        else $error("device late");
    a_ack_hold_high: assert property (scl && !sda_d_oe_n |=> !sda_d_oe_n || !scl) else $error("ack dropped");
    a_scl_high_len: assert property ($rose(scl) |-> scl [*8]) else $error("short high");
    a_scl_low_len: assert property ($fell(scl) |-> !scl [*8]) else $error("short low");
    a_start_by_host: assert property ($fell(sda) && scl |-> sda_d_oe_n && !sda_h_oe_n) else $error("bad start");
    a_stop_frees: assert property ($rose(sda) && scl |=> sda_d_oe_n [*8]) else $error("held after stop");
endmodule
`default_nettype wire

/* sccp_pkg.sv */
`default_nettype none
package sccp_pkg;
    // ********************************
    // Link timing
    // ********************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCL_HALF_NS = 5000;
    // A least time, so round up to whole cycles
    localparam int SCL_HALF_CYCLES = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************************
    // Device map and calibration field
    // ********************************
    localparam int CTRL_LOC = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CAL_MAG_LSB = 0;
    localparam int CAL_MAG_W = 5;
    localparam int CAL_SIGN_BIT = 5;
    localparam int PRE_DIV = 128;
    localparam int STAGE_DIV = 256;
    localparam int CAL_ADD_OSC = 128;
    localparam int CAL_BLANK_OSC = 256;
    localparam int SEC_PER_MIN = 60;
    localparam int CAL_CYCLE_MIN = 64;
    localparam int CAL_LAST_MIN = 62;
    // Terminal counts of the divide-by-256 stage, in whole divide-by-128 pulses
    localparam logic [8:0] STAGE_TERM_NORM = 9'(STAGE_DIV - 1);
    localparam logic [8:0] STAGE_TERM_FAST = 9'(STAGE_DIV - 1 - CAL_ADD_OSC / PRE_DIV);
    localparam logic [8:0] STAGE_TERM_SLOW = 9'(STAGE_DIV - 1 + CAL_BLANK_OSC / PRE_DIV);

    // ********************************
    // Controller registers (Avalon-MM)
    // ********************************
    localparam logic [3:0] CMD_OFF = 4'h0;
    localparam logic [3:0] STAT_OFF = 4'h4;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_READ_BIT = 9;
    localparam int CMD_NACK_BIT = 10;
    localparam int CMD_STOP_BIT = 11;
    localparam int CMD_NOBYTE_BIT = 12;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_RX_LSB = 8;

    // ********************************
    // State machines
    // ********************************
    typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_MACK} sccp_dev_state_e;
    typedef enum logic [3:0] {HS_IDLE, HS_START_A, HS_START_B, HS_START_C, HS_BIT_LOW,
        HS_BIT_HIGH, HS_STOP_A, HS_STOP_B, HS_STOP_C} sccp_host_state_e;
endpackage
`default_nettype wire

/* sccp_tb.sv */
`default_nettype none
module sccp_tb;
    import sccp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // Bench signals
    // ****************
    localparam logic [12:0] S = 13'h100;
    localparam logic [12:0] R = 13'h200;
    localparam logic [12:0] K = 13'h400;
    localparam logic [12:0] P = 13'h800;
    localparam logic [12:0] N = 13'h1000;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic osc_in = 1'b0;
    logic [3:0] address = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    logic [7:0] ctrl;
    logic pwr_fail = 1'b0;
    logic tick;
    logic tick_seen = 1'b0;
    int n_mismatch = 0;
    int cmp_count = 0;
    sccp_link_if link ();
    sccp_host #(.HALF_CYCLES(10)) i_sccp_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link),
        .avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req));
    sccp_device i_sccp_device (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link), .osc_in(osc_in),
        .power_fail_in(pwr_fail), .second_tick_out(tick), .clock_control_out(ctrl));
    sccp_link_monitor i_sccp_link_monitor (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_o(link.scl_o),
        .scl_oe_n(link.scl_oe_n), .sda_h_o(link.sda_h_o), .sda_h_oe_n(link.sda_h_oe_n), .sda_d_o(link.sda_d_o),
        .sda_d_oe_n(link.sda_d_oe_n), .scl(link.scl), .sda(link.sda));
    // Oscillator kept slow against clk_in so the sync flops see every edge
    always #2.5 clk_in = ~clk_in;
    always
    begin
        repeat (16) @(posedge clk_in);
        osc_in <= ~osc_in;
    end
    // Sticky flag: a whole second needs far more oscillator edges than this run has
    always @(posedge clk_in)
    begin
        if (tick === 1'b1)
            tick_seen <= 1'b1;
    end
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until waitrequest is seen low, then released
    task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        address <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        @(posedge clk_in);
        while (wait_req !== 1'b0)
            @(posedge clk_in);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // One link byte; polls status since a byte takes hundreds of cycles
    task automatic xfer(input logic [12:0] c, output logic [7:0] rx, output logic nk);
        logic [31:0] q;
        avs(1'b1, CMD_OFF, {19'h0, c}, q);
        do
            avs(1'b0, STAT_OFF, 32'h0, q);
        while (q[STAT_BUSY_BIT] !== 1'b0);
        rx = q[STAT_RX_LSB +: 8];
        nk = q[STAT_NACK_BIT];
    endtask
    task automatic t_write();
        logic [7:0] rx;
        logic nk;
        xfer(S | 13'hD0, rx, nk);
        chk("addr ack", 8'h00, {7'h0, nk});
        xfer(13'(CTRL_LOC), rx, nk);
        chk("word ack", 8'h00, {7'h0, nk});
        xfer(13'h025, rx, nk);
        chk("data ack", 8'h00, {7'h0, nk});
        xfer(P | 13'h03A, rx, nk);
        chk("ctrl", 8'h25, ctrl);
        $display("t_write done");
    endtask
    // Repeated START read, then a read that reuses the old pointer
    task automatic t_read();
        logic [7:0] rx;
        logic nk;
        xfer(S | 13'hD0, rx, nk);
        xfer(13'(CTRL_LOC), rx, nk);
        xfer(S | 13'hD1, rx, nk);
        xfer(R, rx, nk);
        chk("rd first", 8'h25, rx);
        xfer(R | K | P, rx, nk);
        chk("rd next", 8'h3A, rx);
        xfer(S | 13'hD1, rx, nk);
        xfer(R | K | P, rx, nk);
        chk("rd alt", 8'h3A, rx);
        $display("t_read done");
    endtask
    task automatic t_wrong();
        logic [7:0] rx;
        logic nk;
        xfer(S | P | 13'hA0, rx, nk);
        chk("foreign nack", 8'h01, {7'h0, nk});
        $display("t_wrong done");
    endtask
    // Power fail inside an open frame: bus ignored, pointer back to location zero
    task automatic t_power();
        logic [7:0] rx;
        logic nk;
        xfer(S | 13'hD0, rx, nk);
        xfer(13'h000, rx, nk);
        xfer(13'h05A, rx, nk);
        xfer(N | P, rx, nk);
        xfer(S | 13'hD0, rx, nk);
        xfer(13'(CTRL_LOC), rx, nk);
        pwr_fail <= 1'b1;
        repeat (4) @(posedge clk_in);
        xfer(S | P | 13'hD0, rx, nk);
        chk("pf ignored", 8'h01, {7'h0, nk});
        pwr_fail <= 1'b0;
        repeat (4) @(posedge clk_in);
        xfer(S | 13'hD1, rx, nk);
        xfer(R | K | P, rx, nk);
        chk("pf pointer", 8'h5A, rx);
        chk("early tick", 8'h00, {7'h0, tick_seen});
        $display("t_power done");
    endtask
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************
    // Sequence
    // ****************
    initial
    begin
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_write();
        t_wrong();
        t_read();
        t_power();
        print_verdict();
    end
    // Watchdog: the tests need about 4300 cycles
    initial
    begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
